// ==== bridge_parity_error_report.sv ====
// Purpose: parity error reporting of a two-bus bridge (s_perr, p_serr)
// Assumes: error events come from bridge logic on hclk, one cycle each
// Notes:   enables and status live in AHB-Lite registers
//
// What this block does
// [R1] upstream write target, secondary error: secondary perr only if sec enable
// [R2] downstream read initiator, secondary error: secondary perr if sec enable
// [R3] secondary perr never driven while secondary response enable is clear
// [R4] primary perr on upstream delayed write: secondary perr if both enables
// [R5] serr considered only for perr on upstream or downstream posted writes
// [R6] no serr when bridge found the posted write error as target
// [R7] posted write serr needs primary and secondary enables both set
// [R8] posted write serr also needs the serr enable bit
// [R9] read and delayed write parity errors never raise serr
// [R10] every serr assertion sets the signaled system error status bit
// [R11] perr and serr pins driven active low for one pci clock
// [R12] secondary perr stays released for every other combination
`timescale 1ns/1ps
`default_nettype none

module bridge_parity_error_report
(
  // clock, reset, enable
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // parity error event from the bridge core
  input  wire logic                    err_valid,
  input  wire bridge_perr_pkg::xact_t  err_type,
  input  wire logic                    err_dir,
  input  wire logic                    err_bus,
  input  wire logic                    err_as_target,
  // pins
  output logic                         s_perr_o,
  output logic                         s_perr_oe_n,
  output logic                         p_serr_o,
  output logic                         p_serr_oe_n,
  // interrupt
  output logic                         irq
);

  // ==========================================================
  // decisions
  function automatic logic sperr_fire(
    input bridge_perr_pkg::xact_t t,
    input logic                   dir,
    input logic                   bus,
    input logic                   pen,
    input logic                   sen
  );
    logic hit;
    hit = 1'b0;
    if ((t == bridge_perr_pkg::XT_POSTED || t == bridge_perr_pkg::XT_DELAYED)
        && dir == bridge_perr_pkg::DIR_UP && bus == bridge_perr_pkg::BUS_SEC)
      hit = 1'b1; // R1
    if (t == bridge_perr_pkg::XT_READ && dir == bridge_perr_pkg::DIR_DOWN &&
        bus == bridge_perr_pkg::BUS_SEC)
      hit = 1'b1; // R2
    if (t == bridge_perr_pkg::XT_DELAYED && dir == bridge_perr_pkg::DIR_UP &&
        bus == bridge_perr_pkg::BUS_PRI)
      hit = pen; // R4
    return hit && sen; // R3 R12
  endfunction

  function automatic logic serr_fire(
    input bridge_perr_pkg::xact_t t,
    input logic                   dir,
    input logic                   bus,
    input logic                   tgt,
    input logic [2:0]             c
  );
    logic hit;
    hit = (t == bridge_perr_pkg::XT_POSTED) &&
          ((dir == bridge_perr_pkg::DIR_UP && bus == bridge_perr_pkg::BUS_PRI)
        || (dir == bridge_perr_pkg::DIR_DOWN
            && bus == bridge_perr_pkg::BUS_SEC)); // R5 R9
    return hit && !tgt // R6
      && c[bridge_perr_pkg::CTRL_PPER]
      && c[bridge_perr_pkg::CTRL_SPER] // R7
      && c[bridge_perr_pkg::CTRL_SERR]; // R8
  endfunction

  function automatic logic is_ofs(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    return a == ofs;
  endfunction

  function automatic logic [15:0] sat_inc(
    input logic [15:0] v,
    input logic        inc
  );
    return (inc && v != bridge_perr_pkg::CNT_MAX) ? v + 16'h0001 : v;
  endfunction

  // ==========================================================
  // state
  logic [bridge_perr_pkg::CTRL_W-1:0] ctrl;
  logic [bridge_perr_pkg::STAT_W-1:0] status;
  logic [bridge_perr_pkg::STAT_W-1:0] mask;
  logic [bridge_perr_pkg::INFO_W-1:0] info;
  logic [bridge_perr_pkg::CNT_W-1:0]  serr_cnt;
  logic [bridge_perr_pkg::CNT_W-1:0]  sperr_cnt;
  logic                               dp_wr;
  logic [7:0]                         dp_addr;

  logic [bridge_perr_pkg::CTRL_W-1:0] next_ctrl;
  logic [bridge_perr_pkg::STAT_W-1:0] next_status;
  logic [bridge_perr_pkg::STAT_W-1:0] next_mask;
  logic [bridge_perr_pkg::INFO_W-1:0] next_info;
  logic [bridge_perr_pkg::CNT_W-1:0]  next_serr_cnt;
  logic [bridge_perr_pkg::CNT_W-1:0]  next_sperr_cnt;
  logic                               next_dp_wr;
  logic [7:0]                         next_dp_addr;
  logic [31:0]                        next_hrdata;
  logic                               next_irq;

  logic                               fire_sperr;
  logic                               fire_serr;
  logic                               aphase;
  logic [bridge_perr_pkg::STAT_W-1:0] set_bits;
  logic [bridge_perr_pkg::STAT_W-1:0] clr_bits;

  // ==========================================================
  // event decode
  always_comb
  begin
    fire_sperr = err_valid && sperr_fire(err_type, err_dir, err_bus,
      ctrl[bridge_perr_pkg::CTRL_PPER], ctrl[bridge_perr_pkg::CTRL_SPER]);
    fire_serr  = err_valid && serr_fire(err_type, err_dir, err_bus,
      err_as_target, ctrl);
  end

  pin_pulse
  #(
    .HOLD (bridge_perr_pkg::HOLD_CYCLES)
  )
  u_sperr
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .fire     (fire_sperr),
    .pin_o    (s_perr_o),
    .pin_oe_n (s_perr_oe_n)
  );

  pin_pulse
  #(
    .HOLD (bridge_perr_pkg::HOLD_CYCLES)
  )
  u_serr
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .fire     (fire_serr),
    .pin_o    (p_serr_o),
    .pin_oe_n (p_serr_oe_n)
  );

  // ==========================================================
  // register file next values
  always_comb
  begin
    aphase       = hsel && htrans[1] && hready;
    next_dp_wr   = aphase && hwrite;
    next_dp_addr = aphase ? haddr[7:0] : dp_addr;

    next_ctrl = ctrl;
    next_mask = mask;
    clr_bits  = '0;
    if (dp_wr && is_ofs(dp_addr, bridge_perr_pkg::CTRL_OFS))
      next_ctrl = hwdata[bridge_perr_pkg::CTRL_W-1:0];
    if (dp_wr && is_ofs(dp_addr, bridge_perr_pkg::MASK_OFS))
      next_mask = hwdata[bridge_perr_pkg::STAT_W-1:0];
    if (dp_wr && is_ofs(dp_addr, bridge_perr_pkg::STAT_OFS))
      clr_bits = hwdata[bridge_perr_pkg::STAT_W-1:0];

    set_bits = '0;
    set_bits[bridge_perr_pkg::STAT_SSE]   = fire_serr; // R10
    set_bits[bridge_perr_pkg::STAT_SPERR] = fire_sperr;
    set_bits[bridge_perr_pkg::STAT_EVT]   = err_valid;
    // a new event beats a write-one-to-clear in the same cycle
    next_status = (status & ~clr_bits) | set_bits;

    next_info = info;
    if (err_valid)
      next_info = {err_as_target, err_bus, err_dir, err_type};

    next_serr_cnt  = sat_inc(serr_cnt, fire_serr);
    next_sperr_cnt = sat_inc(sperr_cnt, fire_sperr);
    if (dp_wr && is_ofs(dp_addr, bridge_perr_pkg::SCNT_OFS))
      next_serr_cnt = bridge_perr_pkg::CNT_RST;
    if (dp_wr && is_ofs(dp_addr, bridge_perr_pkg::PCNT_OFS))
      next_sperr_cnt = bridge_perr_pkg::CNT_RST;

    // read data prepared from next values so a write just before is seen
    next_hrdata = 32'h0000_0000;
    if (aphase && !hwrite)
    begin
      if (is_ofs(haddr[7:0], bridge_perr_pkg::CTRL_OFS))
        next_hrdata[bridge_perr_pkg::CTRL_W-1:0] = next_ctrl;
      else if (is_ofs(haddr[7:0], bridge_perr_pkg::STAT_OFS))
        next_hrdata[bridge_perr_pkg::STAT_W-1:0] = next_status;
      else if (is_ofs(haddr[7:0], bridge_perr_pkg::MASK_OFS))
        next_hrdata[bridge_perr_pkg::STAT_W-1:0] = next_mask;
      else if (is_ofs(haddr[7:0], bridge_perr_pkg::INFO_OFS))
        next_hrdata[bridge_perr_pkg::INFO_W-1:0] = next_info;
      else if (is_ofs(haddr[7:0], bridge_perr_pkg::SCNT_OFS))
        next_hrdata[bridge_perr_pkg::CNT_W-1:0] = next_serr_cnt;
      else if (is_ofs(haddr[7:0], bridge_perr_pkg::PCNT_OFS))
        next_hrdata[bridge_perr_pkg::CNT_W-1:0] = next_sperr_cnt;
    end

    next_irq = |(next_status & next_mask);
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl      <= bridge_perr_pkg::CTRL_RST;
      status    <= bridge_perr_pkg::STAT_RST;
      mask      <= bridge_perr_pkg::MASK_RST;
      info      <= bridge_perr_pkg::INFO_RST;
      serr_cnt  <= bridge_perr_pkg::CNT_RST;
      sperr_cnt <= bridge_perr_pkg::CNT_RST;
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
    end
    else if (ce)
    begin
      ctrl      <= next_ctrl;
      status    <= next_status;
      mask      <= next_mask;
      info      <= next_info;
      serr_cnt  <= next_serr_cnt;
      sperr_cnt <= next_sperr_cnt;
      dp_wr     <= next_dp_wr;
      dp_addr   <= next_dp_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= next_irq;
    end
  end

  // ==========================================================
  // checks
  property p_sperr_gate;
    @(posedge hclk) disable iff (!hresetn)
    $fell(s_perr_oe_n) |-> $past(ctrl[bridge_perr_pkg::CTRL_SPER]);
  endproperty
  a_sperr_gate: assert property (p_sperr_gate) // R3
    else $error("secondary perr driven with its enable clear");

  property p_sperr_up_write;
    @(posedge hclk) disable iff (!hresetn)
    (ce && err_valid && (err_type == bridge_perr_pkg::XT_POSTED
     || err_type == bridge_perr_pkg::XT_DELAYED)
     && err_dir == bridge_perr_pkg::DIR_UP
     && err_bus == bridge_perr_pkg::BUS_SEC
     && ctrl[bridge_perr_pkg::CTRL_SPER]) |=> !s_perr_oe_n;
  endproperty
  a_sperr_up_write: assert property (p_sperr_up_write) // R1
    else $error("secondary perr missing on upstream write error");

  property p_sperr_down_read;
    @(posedge hclk) disable iff (!hresetn)
    (ce && err_valid && err_type == bridge_perr_pkg::XT_READ
     && err_dir == bridge_perr_pkg::DIR_DOWN
     && err_bus == bridge_perr_pkg::BUS_SEC
     && ctrl[bridge_perr_pkg::CTRL_SPER]) |=> !s_perr_oe_n;
  endproperty
  a_sperr_down_read: assert property (p_sperr_down_read) // R2
    else $error("secondary perr missing on downstream read error");

  property p_sperr_delayed_pri;
    @(posedge hclk) disable iff (!hresetn)
    (ce && err_valid && err_type == bridge_perr_pkg::XT_DELAYED
     && err_dir == bridge_perr_pkg::DIR_UP
     && err_bus == bridge_perr_pkg::BUS_PRI)
    |=> (!s_perr_oe_n == ($past(ctrl[bridge_perr_pkg::CTRL_PPER])
         && $past(ctrl[bridge_perr_pkg::CTRL_SPER])))
        || $past(!s_perr_oe_n);
  endproperty
  a_sperr_delayed_pri: assert property (p_sperr_delayed_pri) // R4
    else $error("secondary perr wrong on upstream delayed write");

  property p_sperr_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_perr_oe_n && err_dir == bridge_perr_pkg::DIR_DOWN
     && err_type != bridge_perr_pkg::XT_READ) |=> s_perr_oe_n;
  endproperty
  a_sperr_quiet: assert property (p_sperr_quiet) // R12
    else $error("secondary perr driven on a downstream write");

  property p_serr_posted;
    @(posedge hclk) disable iff (!hresetn)
    (ce && err_valid && err_type == bridge_perr_pkg::XT_POSTED
     && ((err_dir == bridge_perr_pkg::DIR_UP
          && err_bus == bridge_perr_pkg::BUS_PRI)
      || (err_dir == bridge_perr_pkg::DIR_DOWN
          && err_bus == bridge_perr_pkg::BUS_SEC))
     && !err_as_target
     && &ctrl) |=> !p_serr_oe_n && status[bridge_perr_pkg::STAT_SSE];
  endproperty
  a_serr_posted: assert property (p_serr_posted) // R5 R7 R8
    else $error("serr missing on posted write error");

  property p_serr_target;
    @(posedge hclk) disable iff (!hresetn)
    (err_as_target && !fire_sperr && p_serr_oe_n) |=> p_serr_oe_n;
  endproperty
  a_serr_target: assert property (p_serr_target) // R6
    else $error("serr raised for an error found as target");

  property p_serr_not_posted;
    @(posedge hclk) disable iff (!hresetn)
    (err_type != bridge_perr_pkg::XT_POSTED && p_serr_oe_n)
    |=> p_serr_oe_n;
  endproperty
  a_serr_not_posted: assert property (p_serr_not_posted) // R9
    else $error("serr raised for a read or delayed write error");

  property p_serr_status;
    @(posedge hclk) disable iff (!hresetn)
    $fell(p_serr_oe_n) |-> status[bridge_perr_pkg::STAT_SSE];
  endproperty
  a_serr_status: assert property (p_serr_status) // R10
    else $error("serr driven without signaled system error status");

  property p_pin_hold;
    @(posedge hclk) disable iff (!hresetn)
    ($fell(s_perr_oe_n) && ce) |-> (!s_perr_oe_n && !s_perr_o) [*2];
  endproperty
  a_pin_hold: assert property (p_pin_hold) // R11
    else $error("secondary perr released too early or driven high");

endmodule

`default_nettype wire

// ==== bridge_perr_pkg.sv ====
// Purpose: shared constants and types of the bridge parity error reporter
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   all offsets are byte addresses within the block's window
package bridge_perr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] MASK_OFS  = 8'h08;
  localparam logic [7:0] INFO_OFS  = 8'h0C;
  localparam logic [7:0] SCNT_OFS  = 8'h10;
  localparam logic [7:0] PCNT_OFS  = 8'h14;
  localparam int         DEC_W     = 8;

  // ==========================================================
  // control fields
  localparam int         CTRL_W    = 3;
  localparam int         CTRL_PPER = 0;
  localparam int         CTRL_SPER = 1;
  localparam int         CTRL_SERR = 2;
  localparam logic [2:0] CTRL_RST  = 3'h0;

  // ==========================================================
  // status and mask fields
  localparam int         STAT_W     = 3;
  localparam int         STAT_SSE   = 0;
  localparam int         STAT_SPERR = 1;
  localparam int         STAT_EVT   = 2;
  localparam logic [2:0] STAT_RST   = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;

  // ==========================================================
  // last event info fields and event counter constants
  localparam int         INFO_W      = 5;
  localparam logic [4:0] INFO_RST    = 5'h00;
  localparam int         CNT_W       = 16;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  // ==========================================================
  // transaction description
  typedef enum logic [1:0]
  {
    XT_READ    = 2'h0,
    XT_POSTED  = 2'h1,
    XT_DELAYED = 2'h2
  } xact_t;

  localparam logic DIR_DOWN = 1'b0;
  localparam logic DIR_UP   = 1'b1;
  localparam logic BUS_PRI  = 1'b0;
  localparam logic BUS_SEC  = 1'b1;

  // ==========================================================
  // pin driver states
  typedef enum logic [1:0]
  {
    PIN_IDLE  = 2'b01,
    PIN_DRIVE = 2'b10
  } pin_state_t;

  // ==========================================================
  // timing: one pci clock period of assertion, rounded up
  localparam int CLK_PERIOD_NS = 5;
  localparam int PCI_PERIOD_NS = 30;
  localparam int HOLD_CYCLES   =
    (PCI_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== pin_pulse.sv ====
// Purpose: active-low pin driver asserting for a fixed number of cycles
// Assumes: fire comes from logic on hclk
// Notes:   pin_oe_n low means the pin is driven; retrigger restarts hold
`timescale 1ns/1ps
`default_nettype none

module pin_pulse
#(
  parameter int HOLD = bridge_perr_pkg::HOLD_CYCLES
)
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // request
  input  wire logic fire,
  // pin
  output logic      pin_o,
  output logic      pin_oe_n
);

  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD - 1);

  bridge_perr_pkg::pin_state_t state;
  bridge_perr_pkg::pin_state_t next_state;
  logic [CW-1:0]               count;
  logic [CW-1:0]               next_count;
  logic                        next_oe_n;

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_oe_n  = pin_oe_n;
    unique case (state)
      bridge_perr_pkg::PIN_IDLE:
      begin
        if (fire)
        begin
          next_state = bridge_perr_pkg::PIN_DRIVE;
          next_count = '0;
          next_oe_n  = 1'b0;
        end
      end
      bridge_perr_pkg::PIN_DRIVE:
      begin
        if (fire)
          next_count = '0;
        else if (count == LAST)
        begin
          next_state = bridge_perr_pkg::PIN_IDLE;
          next_oe_n  = 1'b1;
        end
        else
          next_count = count + CW'(1);
      end
      default:
      begin
        next_state = bridge_perr_pkg::PIN_IDLE;
        next_oe_n  = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // registers; pin level is always low, only the enable moves
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state    <= bridge_perr_pkg::PIN_IDLE;
      count    <= '0;
      pin_oe_n <= 1'b1;
      pin_o    <= 1'b0;
    end
    else if (ce)
    begin
      state    <= next_state;
      count    <= next_count;
      pin_oe_n <= next_oe_n; // R11
      pin_o    <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== pci_pin_model.sv ====
// Purpose: pci side of the perr and serr pins, pulled up when released
// Assumes: pins are open drain, sampled on hclk
// Notes:   reports the length of the last low pulse in hclk cycles
`timescale 1ns/1ps
`default_nettype none

module pci_pin_model
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // pins from the bridge
  input  wire logic       s_perr_o,
  input  wire logic       s_perr_oe_n,
  input  wire logic       p_serr_o,
  input  wire logic       p_serr_oe_n,
  // resolved lines and pulse lengths
  output logic            s_line,
  output logic            p_line,
  output logic [7:0]      s_len,
  output logic [7:0]      p_len
);
  logic [7:0] s_run;
  logic [7:0] p_run;

  // ==========================================================
  // released lines float to the pull-up level
  assign s_line = s_perr_oe_n ? 1'b1 : s_perr_o;
  assign p_line = p_serr_oe_n ? 1'b1 : p_serr_o;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_run <= 8'h00;
      p_run <= 8'h00;
      s_len <= 8'h00;
      p_len <= 8'h00;
    end
    else
    begin
      s_run <= s_line ? 8'h00 : s_run + 8'h01;
      p_run <= p_line ? 8'h00 : p_run + 8'h01;
      if (s_line && s_run != 8'h00)
        s_len <= s_run;
      if (p_line && p_run != 8'h00)
        p_len <= p_run;
    end
  end
endmodule
`default_nettype wire

// ==== tb_bridge_parity_error_report.sv ====
// Purpose: register and event tests of the parity error reporter
// Assumes: zero-wait ahb-lite slave, pin hold of six cycles
// Notes:   every event combination is swept for all enable settings
`timescale 1ns/1ps
`default_nettype none

module tb_bridge_parity_error_report;
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   ce = 1'b1;
  logic                   hsel = 1'b0;
  logic                   hwrite = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic [31:0]            hwdata = 32'h0;
  logic                   hreadyout, hresp, irq;
  logic [31:0]            hrdata, rd;
  logic                   err_valid = 1'b0;
  bridge_perr_pkg::xact_t err_type = bridge_perr_pkg::XT_READ;
  logic                   err_dir = 1'b0, err_bus = 1'b0;
  logic                   err_as_target = 1'b0;
  logic                   s_perr_o, s_perr_oe_n, p_serr_o, p_serr_oe_n;
  logic                   s_line, p_line, d, b, g, es, ep;
  logic [7:0]             s_len, p_len;
  int                     err_total = 0, num_checks = 0;
  int                     n_s = 0, n_p = 0, t;

  always #2.5 hclk = ~hclk;

  bridge_parity_error_report bridge_parity_error_report_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .err_valid(err_valid), .err_type(err_type),
    .err_dir(err_dir), .err_bus(err_bus), .err_as_target(err_as_target),
    .s_perr_o(s_perr_o), .s_perr_oe_n(s_perr_oe_n), .p_serr_o(p_serr_o),
    .p_serr_oe_n(p_serr_oe_n), .irq(irq));

  pci_pin_model pci_pin_model_inst (
    .hclk(hclk), .hresetn(hresetn), .s_perr_o(s_perr_o),
    .s_perr_oe_n(s_perr_oe_n), .p_serr_o(p_serr_o),
    .p_serr_oe_n(p_serr_oe_n), .s_line(s_line), .p_line(p_line),
    .s_len(s_len), .p_len(p_len));

  // ==========================================================
  // report and compare
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] v);
    num_checks++;
    if (v !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask

  // ==========================================================
  // bus cycles, sampled values taken right at the edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? dat : 32'h0;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask

  task automatic fire(input int xt, input logic xd, xb, xg);
    @(posedge hclk);
    err_valid <= 1'b1;
    err_type <= bridge_perr_pkg::xact_t'(xt);
    err_dir <= xd;
    err_bus <= xb;
    err_as_target <= xg;
    @(posedge hclk);
    err_valid <= 1'b0;
  endtask

  task automatic evt();
    fire(t, d, b, g);
    #1;
    chk("s_perr_oe_n", !es, s_perr_oe_n);
    chk("p_serr_oe_n", !ep, p_serr_oe_n);
    repeat (5) @(posedge hclk);
    #1;
    chk("s_line", !es, s_line);
    chk("p_line", !ep, p_line);
    @(posedge hclk);
    #1;
    chk("s_line end", 1, s_line);
    chk("p_line end", 1, p_line);
  endtask

  // ==========================================================
  // expected pin decisions
  function automatic logic exp_s(int xt, logic xd, xb, logic [2:0] c);
    logic up_wr, dn_rd, dly_pri;
    up_wr = (xt == 1 || xt == 2) && xd && xb;
    dn_rd = xt == 0 && !xd && xb;
    dly_pri = xt == 2 && xd && !xb && c[0];
    return c[1] && (up_wr || dn_rd || dly_pri);
  endfunction

  function automatic logic exp_p(int xt, logic xd, xb, xg, logic [2:0] c);
    logic pw;
    pw = xt == 1 && (xd != xb) && !xg;
    return pw && c == 3'h7;
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1, 8'h18, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++)
    begin
      ahb(0, 8'(i * 4), 0);
      chk("reset value", 0, rd);
    end
    ahb(1, 8'h00, 32'hFFFFFFFF);
    ahb(0, 8'h00, 0);
    chk("ctrl", 32'h7, rd);
    for (int c = 0; c < 8; c++)
    begin
      ahb(1, 8'h00, c);
      for (int k = 0; k < 32; k++)
      begin
        t = k / 8;
        d = k[2];
        b = k[1];
        g = k[0];
        es = exp_s(t, d, b, 3'(c));
        ep = exp_p(t, d, b, g, 3'(c));
        n_s += es;
        n_p += ep;
        evt();
        ahb(0, 8'h04, 0);
        chk("status", {29'h0, 1'b1, es, ep}, rd);
        ahb(0, 8'h0C, 0);
        chk("info", {27'h0, g, b, d, t[1:0]}, rd);
        if (es)
          chk("s_len", 6, s_len);
        if (ep)
          chk("p_len", 6, p_len);
        ahb(1, 8'h04, 32'h7);
      end
    end
    // retrigger while held restarts the hold
    fire(1, 1, 0, 0);
    @(posedge hclk);
    fire(1, 1, 0, 0);
    n_p += 2;
    repeat (12) @(posedge hclk);
    chk("p_len retrigger", 9, p_len);
    ahb(0, 8'h10, 0);
    chk("serr count", n_p, rd);
    ahb(0, 8'h14, 0);
    chk("perr count", n_s, rd);
    ahb(1, 8'h10, 0);
    ahb(0, 8'h10, 0);
    chk("serr count clear", 0, rd);
    // events with the clock enable low are lost
    ahb(1, 8'h04, 32'h7);
    ce <= 1'b0;
    fire(1, 1, 0, 0);
    ce <= 1'b1;
    #1;
    chk("p_serr_oe_n ce", 1, p_serr_oe_n);
    ahb(0, 8'h04, 0);
    chk("status ce", 0, rd);
    // interrupt masked, unmasked, cleared
    fire(1, 1, 0, 0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 0, irq);
    ahb(1, 8'h08, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 1, irq);
    ahb(1, 8'h04, 32'h7);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 0, irq);
    wrap_up();
  end
endmodule
`default_nettype wire
